// ==== pbc_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the basic regs
// Assumes: 125 MHz management clock
// Notes:   included by bare name
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

`define PBC_ADDR_W          5
`define PBC_DATA_W          16
`define PBC_ADDR_CTRL       5'h00
`define PBC_ADDR_STAT       5'h01

`define PBC_CB_RESET        15
`define PBC_CB_LOOP         14
`define PBC_CB_SPEED        13
`define PBC_CB_ANEN         12
`define PBC_CB_PDOWN        11
`define PBC_CB_ISO          10
`define PBC_CB_RESTART      9
`define PBC_CB_DUPLEX       8
`define PBC_CB_COLTEST      7

`define PBC_SB_RFAULT       4
`define PBC_SB_ANDONE       5
`define PBC_SB_LINK         2
`define PBC_SB_JABBER       1

`define PBC_CTRL_RESET      16'h3100
`define PBC_STAT_FIXED      16'h7849

`define PBC_CLK_MHZ         125
`define PBC_DEAD_TIME_MS    720
`define PBC_DEAD_CYCLES     (`PBC_DEAD_TIME_MS * 1000 * `PBC_CLK_MHZ)
`define PBC_SRST_CYCLES     16

`endif

// ==== pbc_pkg.sv ====
// Purpose: types shared by the basic control and status block
// Assumes: nothing
// Notes:   constants live in pbc_consts.svh
package pbc_pkg;

  typedef enum logic [0:0] {
    PBC_RUN  = 1'b0,
    PBC_SRST = 1'b1
  } pbc_mode_t;

  typedef struct packed {
    pbc_mode_t   mode;
    logic [4:0]  srstCnt;
    logic        loopback;
    logic        speedSel;
    logic        autoNegEn;
    logic        powerDown;
    logic        isolate;
    logic        restartPend;
    logic        duplexSel;
    logic        colTest;
    logic        loopPrev;
    logic [26:0] deadCnt;
    logic [15:0] rdata;
  } pbc_regs_t;

  typedef struct packed {
    logic status;
  } pbc_latch_t;

  typedef struct packed {
    logic       coreTxEn;
    logic       coreTxEr;
    logic [3:0] coreTxd;
    logic       pinRxDv;
    logic       pinRxEr;
    logic [3:0] pinRxd;
    logic       pinCol;
    logic       pinCrs;
    logic       outOe;
  } pbc_gate_t;

endpackage

// ==== pbc_latch_bit.sv ====
// Purpose: one latching status bit, cleared by a status read
// Assumes: condition is synchronous to sys_clk
// Notes:   LATCH_LOW selects latch-low behaviour
`timescale 1ns/100ps
module pbc_latch_bit
  import pbc_pkg::*;
#(
  parameter bit LATCH_LOW = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic condition,
  input  wire logic readClear,
  output logic      status
);

  pbc_latch_t cur;
  pbc_latch_t next_cur;

  always_comb begin
    next_cur = cur;
    if (clear) begin
      next_cur.status = 1'b0;
    end else if (LATCH_LOW) begin
      // a failure in the read cycle still wins over the clear
      next_cur.status = condition & (cur.status | readClear);
    end else begin
      next_cur.status = condition | (cur.status & ~readClear);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign status = cur.status;

endmodule // pbc_latch_bit

// ==== pbc_mii_gate.sv ====
// Purpose: media-independent interface gating for isolate, power-down and collision test
// Assumes: pin and core signals synchronous to sys_clk
// Notes:   one registered stage on every path
`timescale 1ns/100ps
module pbc_mii_gate
  import pbc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       isolate,
  input  wire logic       powerDown,
  input  wire logic       quiet,
  input  wire logic       colTest,
  input  wire logic       rxHoldoff,
  input  wire logic       pinTxEn,
  input  wire logic       pinTxEr,
  input  wire logic [3:0] pinTxd,
  input  wire logic       coreRxDv,
  input  wire logic       coreRxEr,
  input  wire logic [3:0] coreRxd,
  input  wire logic       coreCol,
  input  wire logic       coreCrs,
  output logic            coreTxEn,
  output logic            coreTxEr,
  output logic [3:0]      coreTxd,
  output logic            pinRxDv,
  output logic            pinRxEr,
  output logic [3:0]      pinRxd,
  output logic            pinCol,
  output logic            pinCrs,
  output logic            miiOutOe
);

  pbc_gate_t cur;
  pbc_gate_t next_cur;
  logic      txBlock;
  logic      rxBlock;

  always_comb begin
    next_cur = '0;
    // power-down and soft reset hold every data and status line low so nothing spurious leaves; the output enable follows isolate
    txBlock = isolate | powerDown | quiet;
    rxBlock = powerDown | quiet | rxHoldoff;
    if (!txBlock) begin
      next_cur.coreTxEn = pinTxEn;
      next_cur.coreTxEr = pinTxEr;
      next_cur.coreTxd  = pinTxd;
    end
    if (!rxBlock) begin
      next_cur.pinRxDv = coreRxDv;
      next_cur.pinRxEr = coreRxEr;
      next_cur.pinRxd  = coreRxd;
    end
    if (!(powerDown | quiet)) begin
      next_cur.pinCol = coreCol | (colTest & pinTxEn);
      next_cur.pinCrs = coreCrs;
    end
    next_cur.outOe = ~isolate;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign coreTxEn = cur.coreTxEn;
  assign coreTxEr = cur.coreTxEr;
  assign coreTxd  = cur.coreTxd;
  assign pinRxDv  = cur.pinRxDv;
  assign pinRxEr  = cur.pinRxEr;
  assign pinRxd   = cur.pinRxd;
  assign pinCol   = cur.pinCol;
  assign pinCrs   = cur.pinCrs;
  assign miiOutOe = cur.outOe;

endmodule // pbc_mii_gate

// ==== pbc_basic_regs.sv ====
// Purpose: basic control and status register pair of a 10/100 transceiver
// Assumes: management frame engine decodes frames into regAddr/regWrite/regRead
// Notes:   read data valid one cycle after regRead
//
// How it works
// - soft reset restores defaults, reads one meanwhile
// - loopback bit enables internal loopback, resets zero
// - loopback at 100M blanks receive data 720ms
// - speed bit one 100M, zero 10M
// - negotiation on: speed reads negotiated value
// - negotiation enable, set at reset, drives speed/duplex
// - power-down still serves management, MII quiet
// - isolate ignores transmit, floats MII outputs
// - restart self-clears once negotiation starts; needs enable
// - writing restart zero leaves negotiation alone
// - duplex writable only with negotiation disabled
// - collision test echoes transmit enable on COL
// - reserved bits read zero, writes ignored
// - capability bits fixed, T4 zero, rest one
// - preamble suppression reads one, accepted
// - negotiation complete mirrors finished negotiation
// - remote fault latches high until status read
// - negotiation ability and extended capability read one
// - link status latches low until read
// - jabber latches high, 10M only, read clears
`timescale 1ns/100ps
`include "pbc_consts.svh"
module pbc_basic_regs
  import pbc_pkg::*;
#(
  parameter int unsigned DEAD_CYCLES = `PBC_DEAD_CYCLES
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic [`PBC_ADDR_W-1:0] regAddr,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  input  wire logic [`PBC_DATA_W-1:0] regWdata,
  output logic      [`PBC_DATA_W-1:0] regRdata,
  input  wire logic                   negSpeed100,
  input  wire logic                   negFullDuplex,
  input  wire logic                   negComplete,
  input  wire logic                   negStarted,
  input  wire logic                   partnerFaultFlag,
  input  wire logic                   linkValid,
  input  wire logic                   jabberSeen,
  input  wire logic                   pinTxEn,
  input  wire logic                   pinTxEr,
  input  wire logic [3:0]             pinTxd,
  input  wire logic                   coreRxDv,
  input  wire logic                   coreRxEr,
  input  wire logic [3:0]             coreRxd,
  input  wire logic                   coreCol,
  input  wire logic                   coreCrs,
  output logic                        coreTxEn,
  output logic                        coreTxEr,
  output logic [3:0]                  coreTxd,
  output logic                        pinRxDv,
  output logic                        pinRxEr,
  output logic [3:0]                  pinRxd,
  output logic                        pinCol,
  output logic                        pinCrs,
  output logic                        miiOutOe,
  output logic                        miiClkOe,
  output logic                        softResetBusy,
  output logic                        loopbackEn,
  output logic                        speed100,
  output logic                        fullDuplex,
  output logic                        autoNegOn,
  output logic                        restartNeg,
  output logic                        powerDownOn,
  output logic                        rxHoldoff
);

  localparam logic [2:0] LATCH_LOW_MASK = 3'b010;
  localparam logic [26:0] DEAD_LOAD     = 27'(DEAD_CYCLES);
  localparam logic [4:0]  SRST_LOAD     = 5'(`PBC_SRST_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  pbc_regs_t        cur;
  pbc_regs_t        next_cur;
  logic             ctrlWrite;
  logic             statRead;
  logic             speedEff;
  logic             duplexEff;
  logic [2:0]       latchCond;
  logic [2:0]       latchState;
  logic [15:0]      ctrlView;
  logic [15:0]      statView;

  assign ctrlWrite = regWrite & (regAddr == `PBC_ADDR_CTRL);
  assign statRead  = regRead & (regAddr == `PBC_ADDR_STAT);

  // negotiated values replace the written ones while negotiation is on
  assign speedEff  = cur.autoNegEn ? negSpeed100 : cur.speedSel;
  assign duplexEff = cur.autoNegEn ? negFullDuplex : cur.duplexSel;

  ////////////////////////////////////////////////////////////////////////////////
  // latching status bits: 0 remote fault, 1 link, 2 jabber

  assign latchCond[0] = partnerFaultFlag;
  assign latchCond[1] = linkValid;
  assign latchCond[2] = jabberSeen & ~speedEff;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_latch
      pbc_latch_bit #(
        .LATCH_LOW (LATCH_LOW_MASK[gi])
      ) u_latch (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clear     (cur.mode == PBC_SRST),
        .condition (latchCond[gi]),
        .readClear (statRead),
        .status    (latchState[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // read views

  always_comb begin
    ctrlView = '0;
    ctrlView[`PBC_CB_RESET]   = (cur.mode == PBC_SRST);
    ctrlView[`PBC_CB_LOOP]    = cur.loopback;
    ctrlView[`PBC_CB_SPEED]   = speedEff;
    ctrlView[`PBC_CB_ANEN]    = cur.autoNegEn;
    ctrlView[`PBC_CB_PDOWN]   = cur.powerDown;
    ctrlView[`PBC_CB_ISO]     = cur.isolate;
    ctrlView[`PBC_CB_RESTART] = cur.restartPend;
    ctrlView[`PBC_CB_DUPLEX]  = duplexEff;
    ctrlView[`PBC_CB_COLTEST] = cur.colTest;
  end

  always_comb begin
    // fixed capabilities, preamble suppression and reserved zeros
    statView = `PBC_STAT_FIXED;
    statView[`PBC_SB_ANDONE] = negComplete & cur.autoNegEn & (cur.mode == PBC_RUN);
    statView[`PBC_SB_RFAULT] = latchState[0];
    statView[`PBC_SB_LINK]   = latchState[1];
    statView[`PBC_SB_JABBER] = latchState[2];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_cur = cur;
    next_cur.loopPrev = cur.loopback;

    unique case (cur.mode)
      PBC_RUN: begin
        if (ctrlWrite) begin
          if (regWdata[`PBC_CB_RESET]) begin
            // every control bit back to default at once; busy flag holds
            next_cur.mode        = PBC_SRST;
            next_cur.srstCnt     = SRST_LOAD;
            next_cur.loopback    = 1'(`PBC_CTRL_RESET >> `PBC_CB_LOOP);
            next_cur.speedSel    = 1'(`PBC_CTRL_RESET >> `PBC_CB_SPEED);
            next_cur.autoNegEn   = 1'(`PBC_CTRL_RESET >> `PBC_CB_ANEN);
            next_cur.powerDown   = 1'(`PBC_CTRL_RESET >> `PBC_CB_PDOWN);
            next_cur.isolate     = 1'(`PBC_CTRL_RESET >> `PBC_CB_ISO);
            next_cur.restartPend = 1'b0;
            next_cur.duplexSel   = 1'(`PBC_CTRL_RESET >> `PBC_CB_DUPLEX);
            next_cur.colTest     = 1'(`PBC_CTRL_RESET >> `PBC_CB_COLTEST);
          end else begin
            next_cur.loopback  = regWdata[`PBC_CB_LOOP];
            next_cur.speedSel  = regWdata[`PBC_CB_SPEED];
            next_cur.autoNegEn = regWdata[`PBC_CB_ANEN];
            next_cur.powerDown = regWdata[`PBC_CB_PDOWN];
            next_cur.isolate   = regWdata[`PBC_CB_ISO];
            next_cur.duplexSel = regWdata[`PBC_CB_DUPLEX];
            next_cur.colTest   = regWdata[`PBC_CB_COLTEST];
          end
        end
        // restart: a written one arms only with enable also written one; a written zero disarms only with enable written zero
        if (cur.restartPend && negStarted) begin
          next_cur.restartPend = 1'b0;
        end
        if (ctrlWrite && !regWdata[`PBC_CB_RESET] && regWdata[`PBC_CB_RESTART]
            && regWdata[`PBC_CB_ANEN]) begin
          next_cur.restartPend = 1'b1;
        end
        if (ctrlWrite && !regWdata[`PBC_CB_ANEN]) begin
          // disabled negotiation leaves restart without function
          next_cur.restartPend = 1'b0;
        end
      end
      PBC_SRST: begin
        // writes during the reset sequence are dropped
        if (cur.srstCnt == 5'h00) begin
          next_cur.mode = PBC_RUN;
        end else begin
          next_cur.srstCnt = cur.srstCnt - 5'h01;
        end
      end
    endcase

    // dead time after loopback at 100M; limitation: a fixed worst-case blank
    if (cur.loopback && !cur.loopPrev && speedEff) begin
      next_cur.deadCnt = DEAD_LOAD;
    end else if (!cur.loopback) begin
      next_cur.deadCnt = '0;
    end else if (cur.deadCnt != 27'h0000000) begin
      next_cur.deadCnt = cur.deadCnt - 27'h0000001;
    end

    // read data registered; unmapped addresses read zero
    if (regRead) begin
      if (regAddr == `PBC_ADDR_CTRL) begin
        next_cur.rdata = ctrlView;
      end else if (regAddr == `PBC_ADDR_STAT) begin
        next_cur.rdata = statView;
      end else begin
        next_cur.rdata = '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur           <= '0;
      cur.speedSel  <= 1'b1;
      cur.autoNegEn <= 1'b1;
      cur.duplexSel <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // MII gating

  pbc_mii_gate u_gate (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .isolate   (cur.isolate),
    .powerDown (cur.powerDown),
    .quiet     (cur.mode == PBC_SRST),
    .colTest   (cur.colTest),
    .rxHoldoff (cur.deadCnt != 27'h0000000),
    .pinTxEn   (pinTxEn),
    .pinTxEr   (pinTxEr),
    .pinTxd    (pinTxd),
    .coreRxDv  (coreRxDv),
    .coreRxEr  (coreRxEr),
    .coreRxd   (coreRxd),
    .coreCol   (coreCol),
    .coreCrs   (coreCrs),
    .coreTxEn  (coreTxEn),
    .coreTxEr  (coreTxEr),
    .coreTxd   (coreTxd),
    .pinRxDv   (pinRxDv),
    .pinRxEr   (pinRxEr),
    .pinRxd    (pinRxd),
    .pinCol    (pinCol),
    .pinCrs    (pinCrs),
    .miiOutOe  (miiOutOe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign regRdata      = cur.rdata;
  assign miiClkOe      = ~cur.isolate;
  assign softResetBusy = (cur.mode == PBC_SRST);
  assign loopbackEn    = cur.loopback;
  assign speed100      = speedEff;
  assign fullDuplex    = duplexEff;
  assign autoNegOn     = cur.autoNegEn;
  assign restartNeg    = cur.restartPend;
  assign powerDownOn   = cur.powerDown;
  assign rxHoldoff     = (cur.deadCnt != 27'h0000000);

endmodule // pbc_basic_regs

// ==== pbc_basic_regs_checker.sv ====
// Purpose: port-level checks of the basic control and status block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every pbc_basic_regs instance at the foot of this file
`timescale 1ns/100ps
`include "pbc_consts.svh"
module pbc_basic_regs_checker
  import pbc_pkg::*;
#(
  parameter int unsigned DEAD_CYCLES = `PBC_DEAD_CYCLES
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [4:0]  regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        negSpeed100,
  input wire logic        negFullDuplex,
  input wire logic        negStarted,
  input wire logic        coreCol,
  input wire logic        coreTxEn,
  input wire logic        coreTxEr,
  input wire logic        pinRxDv,
  input wire logic        pinRxEr,
  input wire logic        pinCol,
  input wire logic        pinCrs,
  input wire logic        miiOutOe,
  input wire logic        miiClkOe,
  input wire logic        softResetBusy,
  input wire logic        loopbackEn,
  input wire logic        speed100,
  input wire logic        fullDuplex,
  input wire logic        autoNegOn,
  input wire logic        restartNeg,
  input wire logic        powerDownOn,
  input wire logic        rxHoldoff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // cycles spent in soft reset; a repetition of 16 would be too slow to unroll
  logic [4:0] busyCnt;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !softResetBusy) busyCnt <= 5'h00;
    else busyCnt <= busyCnt + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_ctrl_wr;
    regWrite && regAddr == `PBC_ADDR_CTRL && !softResetBusy;
  endsequence
  sequence s_restart_wr;
    s_ctrl_wr ##0 (regWdata[9] && regWdata[12] && !regWdata[15]);
  endsequence
  a_srst_entry: assert property (s_ctrl_wr ##0 regWdata[15] |=> softResetBusy)
    else $error("soft reset did not start");
  a_srst_length: assert property ($fell(softResetBusy) && $past(rst_n) |-> busyCnt == 5'h10)
    else $error("soft reset length wrong");
  a_restart_set: assert property (s_restart_wr |=> restartNeg)
    else $error("restart not pending");
  a_restart_keep: assert property ((restartNeg && !negStarted) ##0 s_ctrl_wr ##0
    (regWdata[12] && !regWdata[15]) |=> restartNeg) else $error("restart dropped");
  a_restart_done: assert property (restartNeg && negStarted && !regWrite |=> !restartNeg)
    else $error("restart did not clear");
  a_ctrl_read: assert property (regRead && regAddr == `PBC_ADDR_CTRL |=>
    {regRdata[15:11], regRdata[9:8], regRdata[6:0]} == {$past(softResetBusy),
    $past(loopbackEn), $past(speed100), $past(autoNegOn), $past(powerDownOn),
    $past(restartNeg), $past(fullDuplex), 7'h00}) else $error("control readback wrong");
  a_stat_fixed: assert property (regRead && regAddr == `PBC_ADDR_STAT |=>
    (regRdata & 16'hffc9) == `PBC_STAT_FIXED) else $error("status fixed bits wrong");
  a_unmapped: assert property (regRead && regAddr > `PBC_ADDR_STAT |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  a_neg_mux: assert property (autoNegOn |-> speed100 == negSpeed100 &&
    fullDuplex == negFullDuplex) else $error("negotiated mode not used");
  a_pdown_quiet: assert property (powerDownOn |=> !(pinRxDv || pinCol || pinCrs || coreTxEn))
    else $error("activity in power-down");
  a_iso_float: assert property (!miiClkOe |=> !(miiOutOe || coreTxEn || coreTxEr))
    else $error("isolate not honoured");
  a_col_echo: assert property (coreCol && !powerDownOn && !softResetBusy |=> pinCol)
    else $error("collision not passed");
  a_holdoff_blank: assert property (rxHoldoff |=> !(pinRxDv || pinRxEr))
    else $error("receive not blanked");
endmodule // pbc_basic_regs_checker

bind pbc_basic_regs pbc_basic_regs_checker #(.DEAD_CYCLES(DEAD_CYCLES)) u_chk (
  .sys_clk, .rst_n, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .negSpeed100,
  .negFullDuplex, .negStarted, .coreCol, .coreTxEn, .coreTxEr, .pinRxDv, .pinRxEr, .pinCol,
  .pinCrs, .miiOutOe, .miiClkOe, .softResetBusy, .loopbackEn, .speed100, .fullDuplex,
  .autoNegOn, .restartNeg, .powerDownOn, .rxHoldoff
);

// ==== pbc_mgmt_model.sv ====
// Purpose: station management side issuing register reads and writes
// Assumes: strobes taken at the rising edge, read data valid one cycle later
// Notes:   released address and data are inverted so stale values never match
`timescale 1ns/100ps
`include "pbc_consts.svh"
module pbc_mgmt_model
  import pbc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] regRdata,
  output logic      [4:0]  regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic      [15:0] regWdata
);
  initial begin
    regAddr = 5'h1f;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (a == `PBC_ADDR_CTRL && !d[12]) d[9] = 1'b0;
    @(negedge sys_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(negedge sys_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge sys_clk);
    regRead = 1'b0;
    regAddr = ~a;
    q = regRdata;
  endtask
endmodule // pbc_mgmt_model

// ==== pbc_basic_regs_tb.sv ====
// Purpose: self-checking bench for the basic control and status block
// Assumes: inputs change on the falling edge
// Notes:   a bit-level model of both registers predicts every read
`timescale 1ns/100ps
`include "pbc_consts.svh"
module pbc_basic_regs_tb
  import pbc_pkg::*;
;
  localparam int unsigned DEAD = 20;
  logic        sys_clk, rst_n, regWrite, regRead, negSpeed100, negFullDuplex;
  logic        negComplete, negStarted, partnerFaultFlag, linkValid, jabberSeen;
  logic        pinTxEn, pinTxEr, coreRxDv, coreRxEr, coreCol, coreCrs, coreTxEn, coreTxEr;
  logic        pinRxDv, pinRxEr, pinCol, pinCrs, miiOutOe, miiClkOe, softResetBusy;
  logic        loopbackEn, speed100, fullDuplex, autoNegOn, restartNeg, powerDownOn, rxHoldoff;
  logic [4:0]  regAddr;
  logic [15:0] regWdata, regRdata;
  logic [3:0]  pinTxd, coreRxd, coreTxd, pinRxd;
  int          errors, checks_done, cycles;
  bit          loop, spd, anen, pd, iso, rs, dup, col, srst, lf, ll, lj;
  pbc_mgmt_model m (.sys_clk, .regRdata, .regAddr, .regWrite, .regRead, .regWdata);
  pbc_basic_regs #(.DEAD_CYCLES(DEAD)) dut (.sys_clk, .rst_n, .regAddr, .regWrite, .regRead,
    .regWdata, .regRdata, .negSpeed100, .negFullDuplex, .negComplete, .negStarted,
    .partnerFaultFlag, .linkValid, .jabberSeen, .pinTxEn, .pinTxEr, .pinTxd, .coreRxDv,
    .coreRxEr, .coreRxd, .coreCol, .coreCrs, .coreTxEn, .coreTxEr, .coreTxd, .pinRxDv,
    .pinRxEr, .pinRxd, .pinCol, .pinCrs, .miiOutOe, .miiClkOe, .softResetBusy, .loopbackEn,
    .speed100, .fullDuplex, .autoNegOn, .restartNeg, .powerDownOn, .rxHoldoff);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] ectl();
    ectl = {srst, loop, anen ? negSpeed100 : spd, anen, pd, iso, rs,
            anen ? negFullDuplex : dup, col, 7'h00};
  endfunction
  function automatic logic [15:0] est();
    est = `PBC_STAT_FIXED | {10'h000, negComplete & anen & !srst, lf, 1'b0, ll, lj, 1'b0};
  endfunction
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    m.rd(a, q);
    chk(q, e);
  endtask
  // model follows only what a completed write would change
  task automatic wc(input logic [15:0] d);
    m.wr(`PBC_ADDR_CTRL, d);
    {loop, spd, anen, pd, iso} = d[14:10];
    {dup, col} = d[8:7];
    rs = d[12] & (rs | d[9]);
  endtask
  task automatic pulse(input int k);
    @(negedge sys_clk);
    case (k)
      0: partnerFaultFlag = 1'b1;
      1: linkValid = 1'b0;
      default: jabberSeen = 1'b1;
    endcase
    repeat (2) @(negedge sys_clk);
    partnerFaultFlag = 1'b0;
    linkValid = 1'b1;
    jabberSeen = 1'b0;
  endtask
  task automatic mii(input logic [3:0] e);
    @(negedge sys_clk);
    chk({4'h0, pinCol, coreTxEn, pinRxDv, pinCrs, coreTxd, pinRxd},
        {4'h0, e, e[2] ? pinTxd : 4'h0, e[1] ? coreRxd : 4'h0});
  endtask
  // latched status bits, with a timeout kept on the same clock
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      results();
    end
    if (!rst_n || srst) {lf, ll, lj} <= 3'b000;
    else if (regRead && regAddr == `PBC_ADDR_STAT)
      {lf, ll, lj} <= {partnerFaultFlag, linkValid, jabberSeen & !(anen ? negSpeed100 : spd)};
    else
      {lf, ll, lj} <= {lf | partnerFaultFlag, ll & linkValid,
                       lj | (jabberSeen & !(anen ? negSpeed100 : spd))};
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, negComplete, negStarted, partnerFaultFlag, jabberSeen, pinTxEn} = 6'h00;
    {pinTxEr, coreRxDv, coreRxEr, coreCol, coreCrs, pinTxd, coreRxd} = 13'h0000;
    {negSpeed100, negFullDuplex, linkValid} = 3'b111;
    {loop, spd, anen, pd, iso, rs, dup, col} = 8'h62;
    void'($urandom(32'he01f7e7f));
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    rdc(`PBC_ADDR_CTRL, ectl());
    rdc(`PBC_ADDR_STAT, est());
    m.wr(`PBC_ADDR_STAT, 16'hffff);
    rdc(`PBC_ADDR_STAT, est());
    for (int i = 0; i < 4; i++) rdc(5'h02 + 5'($urandom_range(29)), 16'h0000);
    for (int i = 0; i < 24; i++) begin
      {negSpeed100, negFullDuplex} = 2'($urandom);
      wc(16'($urandom) & 16'h7fff);
      rdc(`PBC_ADDR_CTRL, ectl());
    end
    wc(16'h1000);
    wc(16'h1200);
    rdc(`PBC_ADDR_CTRL, ectl());
    wc(16'h1000);
    rdc(`PBC_ADDR_CTRL, ectl());
    negStarted = 1'b1;
    @(negedge sys_clk);
    negStarted = 1'b0;
    rs = 1'b0;
    rdc(`PBC_ADDR_CTRL, ectl());
    negComplete = 1'b1;
    rdc(`PBC_ADDR_STAT, est());
    wc(16'h0000);
    rdc(`PBC_ADDR_STAT, est());
    negComplete = 1'b0;
    for (int k = 0; k < 3; k++) begin
      rdc(`PBC_ADDR_STAT, est());
      pulse(k);
      rdc(`PBC_ADDR_STAT, est());
      rdc(`PBC_ADDR_STAT, est());
    end
    wc(16'h2000);
    pulse(2);
    rdc(`PBC_ADDR_STAT, est());
    partnerFaultFlag = 1'b1;
    // let the fault latch before the expected value is taken
    @(negedge sys_clk);
    repeat (2) rdc(`PBC_ADDR_STAT, est());
    partnerFaultFlag = 1'b0;
    {pinTxEn, coreRxDv, coreCrs} = 3'b111;
    {pinTxd, coreRxd} = 8'($urandom);
    coreCol = 1'b1;
    mii(4'hf);
    coreCol = 1'b0;
    wc(16'h0080);
    mii(4'hf);
    chk({14'h0000, miiOutOe, miiClkOe}, 16'h0003);
    wc(16'h0000);
    mii(4'h7);
    wc(16'h0400);
    mii(4'h3);
    chk({14'h0000, miiOutOe, miiClkOe}, 16'h0000);
    wc(16'h0800);
    mii(4'h0);
    rdc(`PBC_ADDR_CTRL, ectl());
    wc(16'h2000);
    wc(16'h6000);
    repeat (4) @(negedge sys_clk);
    chk({14'h0000, rxHoldoff, pinRxDv}, 16'h0002);
    repeat (DEAD + 4) @(negedge sys_clk);
    chk({14'h0000, rxHoldoff, pinRxDv}, 16'h0001);
    wc(16'h0000);
    wc(16'h4000);
    repeat (4) @(negedge sys_clk);
    chk({14'h0000, rxHoldoff, pinRxDv}, 16'h0001);
    m.wr(`PBC_ADDR_CTRL, 16'h8000 | 16'($urandom));
    srst = 1'b1;
    {loop, spd, anen, pd, iso, rs, dup, col} = 8'h62;
    rdc(`PBC_ADDR_CTRL, ectl());
    m.wr(`PBC_ADDR_CTRL, 16'h0000);
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    rdc(`PBC_ADDR_CTRL, ectl());
    rdc(`PBC_ADDR_STAT, est());
    results();
  end
endmodule // pbc_basic_regs_tb
